// ==== sim/dtc_event_source.sv ====
/*
   dtc_event_source: far-side model driving the two external event pins.
   Assumes the bench calls drive() and that pins move only after pclk rises.
*/
`timescale 1ns/1ps
`default_nettype none

module dtc_event_source
(
   // clock
   input wire logic pclk,
   // event pins
   output var logic counter0_input,
   output var logic counter1_input
);
   // pins start low so the first rise is a clean event
   initial
   begin
      counter0_input = 1'b0;
      counter1_input = 1'b0;
   end

   // level change just after a rising edge, like a synchronous source
   task automatic drive(input int ch, input logic lvl);
      @(posedge pclk);
      if (ch == 0)
         counter0_input <= lvl;
      else
         counter1_input <= lvl;
   endtask : drive
endmodule : dtc_event_source

`default_nettype wire

// ==== sim/tb_dtc_timer.sv ====
/*
   tb_dtc_timer: self-checking bench for dtc_timer over apb.
   Assumes the default build options: counter 0 sysclk/4, counter 1 fed
   by counter 0 overflow, divider from counter 0.
*/
`timescale 1ns/1ps
`default_nettype none

module tb_dtc_timer
   import dtc_pkg::*;
;
   logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic rtc_tick, timebase_tick, counter0_input, counter1_input;
   logic counter0_irq_req, counter1_irq_req, freq_divider_out, port_a_bit3;
   logic counter0_overflow, counter1_overflow;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   int errors, check_count, cycles, ovf0, ovf1;

   // 20 mhz clock
   initial
   begin
      pclk = 1'b0;
      forever #25 pclk = ~pclk;
   end

   dtc_timer u_dtc_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .rtc_tick(rtc_tick), .timebase_tick(timebase_tick),
      .counter0_input(counter0_input), .counter1_input(counter1_input),
      .counter0_irq_req(counter0_irq_req),
      .counter1_irq_req(counter1_irq_req),
      .counter0_overflow(counter0_overflow),
      .counter1_overflow(counter1_overflow),
      .freq_divider_out(freq_divider_out), .port_a_bit3(port_a_bit3));

   dtc_event_source u_dtc_event_source (.pclk(pclk),
      .counter0_input(counter0_input), .counter1_input(counter1_input));

   // wake pulses counted here; the ceiling cuts a hung run short
   always @(posedge pclk)
   begin
      cycles++;
      if (counter0_overflow === 1'b1)
         ovf0++;
      if (counter1_overflow === 1'b1)
         ovf1++;
      if (cycles == 5000)
      begin
         errors++;
         give_verdict();
      end
   end

   function automatic logic [7:0] ad(input logic [7:0] idx);
      return {idx[5:0], 2'b00};
   endfunction : ad

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // one apb transfer; read data and error taken at the pready edge
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= {24'h0, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1 && n < 16)
      begin
         n++;
         @(posedge pclk);
      end
      if (n == 16)
         errors++;
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : xfer

   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      xfer(ad(idx), 1'b1, d);
   endtask : wr

   task automatic rdc(input string nm, input logic [7:0] idx,
                      input logic [7:0] e);
      xfer(ad(idx), 1'b0, 8'h00);
      chk(nm, {24'h0, e}, rd);
   endtask : rdc

   // one-cycle rtc ticks with a gap, so each is seen once
   task automatic tick(input int n);
      repeat (n)
      begin
         @(posedge pclk);
         rtc_tick <= 1'b1;
         @(posedge pclk);
         rtc_tick <= 1'b0;
      end
   endtask : tick

   task automatic idle(input int n);
      repeat (n) @(posedge pclk);
   endtask : idle

   task automatic pin(input int ch, input logic lvl);
      u_dtc_event_source.drive(ch, lvl);
      idle(5);
   endtask : pin

   task automatic give_verdict();
      $display("checks %0d errors %0d", check_count, errors);
      if (errors == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict

   initial
   begin
      {psel, penable, pwrite, rtc_tick, timebase_tick} = 5'h00;
      paddr = 8'h00;
      pwdata = 32'h0;
      presetn = 1'b0;
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      rdc("c0 ctl", DTC_IDX_C0_CTL, 8'h08);
      rdc("c1 ctl", DTC_IDX_C1_CTL, 8'h08);
      rdc("irq a", DTC_IDX_IRQ_A, 8'h00);
      rdc("irq b", DTC_IDX_IRQ_B, 8'h00);
      rdc("port a", DTC_IDX_PORT_A, 8'hFF);
      wr(DTC_IDX_C0_CTL, 8'hEF);
      rdc("c0 ctl low bits", DTC_IDX_C0_CTL, 8'hE8);
      xfer(8'h00, 1'b0, 8'h00);
      chk("unmapped err", 32'h1, {31'h0, er});
      chk("unmapped data", 32'h0, rd);
      chk("pa3 idle", 32'h1, {31'h0, port_a_bit3});
      // run set then cleared once before real use
      wr(DTC_IDX_C0_CTL, 8'h10);
      wr(DTC_IDX_C0_CTL, 8'h00);
      wr(DTC_IDX_C1_CTL, 8'h10);
      wr(DTC_IDX_C1_CTL, 8'h00);
      wr(DTC_IDX_C0_DATA, 8'h5A);
      rdc("stopped load", DTC_IDX_C0_DATA, 8'h5A);
      $display("test reset done");

      // timer mode on rtc ticks, counter 1 cascaded on its overflow
      wr(DTC_IDX_C1_DATA, 8'h00);
      wr(DTC_IDX_C1_CTL, 8'h90);
      wr(DTC_IDX_C0_DATA, 8'hFE);
      wr(DTC_IDX_C0_CTL, 8'h90);
      tick(1);
      rdc("count up", DTC_IDX_C0_DATA, 8'hFF);
      tick(1);
      rdc("flag0", DTC_IDX_IRQ_A, 8'h40);
      chk("req0 masked", 32'h0, {31'h0, counter0_irq_req});
      rdc("reload", DTC_IDX_C0_DATA, 8'hFE);
      chk("divider", 32'h1, {31'h0, freq_divider_out});
      wr(DTC_IDX_IRQ_A, 8'h48);
      wr(DTC_IDX_PORT_A, 8'hF7);
      wr(DTC_IDX_C0_DATA, 8'h10);
      idle(1);
      chk("req0 on", 32'h1, {31'h0, counter0_irq_req});
      chk("pa3 div", 32'h1, {31'h0, port_a_bit3});
      rdc("run write", DTC_IDX_C0_DATA, 8'hFE);
      tick(2);
      idle(2);
      rdc("new preload", DTC_IDX_C0_DATA, 8'h10);
      chk("pa3 toggled", 32'h0, {31'h0, port_a_bit3});
      rdc("cascade", DTC_IDX_C1_DATA, 8'h02);
      chk("wake pulses", 32'd2, ovf0);
      rdc("run kept", DTC_IDX_C0_CTL, 8'h90);
      wr(DTC_IDX_PORT_A, 8'hFF);
      wr(DTC_IDX_IRQ_A, 8'h00);
      idle(1);
      chk("pa3 off", 32'h1, {31'h0, port_a_bit3});
      chk("req0 off", 32'h0, {31'h0, counter0_irq_req});
      $display("test timer done");

      // event mode, rising then falling active edge
      wr(DTC_IDX_C1_CTL, 8'h00);
      wr(DTC_IDX_C1_DATA, 8'h00);
      for (int e = 0; e < 2; e++)
      begin
         wr(DTC_IDX_C1_CTL, 8'(8'h50 | (e << 3)));
         pin(1, 1'b1);
         rdc("rise", DTC_IDX_C1_DATA, 8'h01);
         pin(1, 1'b0);
         rdc("fall", DTC_IDX_C1_DATA, 8'(1 + e));
      end
      // counter 1 overflow from ff raises its flag and, enabled, its request
      wr(DTC_IDX_IRQ_B, 8'h01);
      wr(DTC_IDX_C1_CTL, 8'h00);
      wr(DTC_IDX_C1_DATA, 8'hFF);
      wr(DTC_IDX_C1_CTL, 8'h50);
      pin(1, 1'b1);
      pin(1, 1'b0);
      rdc("flag1", DTC_IDX_IRQ_B, 8'h11);
      chk("req1 on", 32'h1, {31'h0, counter1_irq_req});
      chk("wake1", 32'd1, ovf1);
      $display("test event done");

      // counter 0 on clock/4: forty enabled edges give ten counts, any phase
      wr(DTC_IDX_C0_CTL, 8'h00);
      wr(DTC_IDX_C0_DATA, 8'h00);
      wr(DTC_IDX_C0_CTL, 8'hB0);
      idle(37);
      wr(DTC_IDX_C0_CTL, 8'h20);
      rdc("clock/4", DTC_IDX_C0_DATA, 8'h0A);
      $display("test clock4 done");

      // pulse width on counter 0, one shot then rearm
      wr(DTC_IDX_C0_CTL, 8'h00);
      wr(DTC_IDX_C0_DATA, 8'h00);
      wr(DTC_IDX_C0_CTL, 8'hD0);
      tick(2);
      pin(0, 1'b1);
      tick(5);
      pin(0, 1'b0);
      tick(3);
      rdc("width", DTC_IDX_C0_DATA, 8'h05);
      rdc("run cleared", DTC_IDX_C0_CTL, 8'hC0);
      pin(0, 1'b1);
      tick(2);
      pin(0, 1'b0);
      rdc("held", DTC_IDX_C0_DATA, 8'h05);
      wr(DTC_IDX_C0_CTL, 8'hD0);
      pin(0, 1'b1);
      tick(1);
      pin(0, 1'b0);
      rdc("rearmed", DTC_IDX_C0_DATA, 8'h06);
      $display("test pulse done");
      give_verdict();
   end
endmodule : tb_dtc_timer

`default_nettype wire

// ==== verilog/dtc_pkg.sv ====
/*
   dtc_pkg: register indices, field positions, reset values and encodings
   for the dual 8-bit timer/event counter.
   Assumes a 32-bit APB slave where byte address = 4 * register index.
*/
`default_nettype none

package dtc_pkg;

   // register indices; byte address is four times the index
   localparam logic [7:0] DTC_IDX_IRQ_A = 8'h0B;
   localparam logic [7:0] DTC_IDX_IRQ_B = 8'h0C;
   localparam logic [7:0] DTC_IDX_C0_DATA = 8'h0D;
   localparam logic [7:0] DTC_IDX_C0_CTL = 8'h0E;
   localparam logic [7:0] DTC_IDX_C1_DATA = 8'h10;
   localparam logic [7:0] DTC_IDX_C1_CTL = 8'h11;
   localparam logic [7:0] DTC_IDX_PORT_A = 8'h12;

   // control register fields
   localparam int unsigned DTC_CTL_MODE_HI = 7;
   localparam int unsigned DTC_CTL_MODE_LO = 6;
   localparam int unsigned DTC_CTL_SRC = 5;
   localparam int unsigned DTC_CTL_RUN = 4;
   localparam int unsigned DTC_CTL_EDGE = 3;
   localparam logic [7:0] DTC_CTL_MASK = 8'hF8;

   // interrupt control fields
   localparam int unsigned DTC_IRQA_EN0 = 3;
   localparam int unsigned DTC_IRQA_FLAG0 = 6;
   localparam int unsigned DTC_IRQB_EN1 = 0;
   localparam int unsigned DTC_IRQB_FLAG1 = 4;
   localparam logic [7:0] DTC_IRQA_MASK = 8'h7F;
   localparam logic [7:0] DTC_IRQB_MASK = 8'h77;
   localparam int unsigned DTC_PA_DIV_BIT = 3;

   // reset values
   localparam logic [7:0] DTC_CTL_RESET = 8'h08;
   localparam logic [7:0] DTC_IRQ_RESET = 8'h00;
   localparam logic [7:0] DTC_PORT_A_RESET = 8'hFF;
   localparam logic [7:0] DTC_CNT_RESET = 8'h00;

   // counting constants
   localparam logic [7:0] DTC_CNT_MAX = 8'hFF;
   localparam logic [7:0] DTC_CNT_ONE = 8'h01;
   localparam logic [1:0] DTC_DIV4_LAST = 2'h3;

   // operating modes from control bits 7:6
   typedef enum logic [1:0]
   {
      DTC_MODE_OFF = 2'h0,
      DTC_MODE_EVENT = 2'h1,
      DTC_MODE_TIMER = 2'h2,
      DTC_MODE_PULSE = 2'h3
   } dtc_mode_e;

   // pulse-width measurement states
   typedef enum logic
   {
      DTC_PW_ARMED = 1'b0,
      DTC_PW_COUNT = 1'b1
   } dtc_pw_e;

   // build-time source for counter 1 when its select bit is 0
   typedef enum logic [1:0]
   {
      DTC_C1_FROM_OVF0 = 2'h0,
      DTC_C1_FROM_SYS = 2'h1,
      DTC_C1_FROM_TB = 2'h2
   } dtc_c1src_e;

   // build-time routing of the divider output
   typedef enum logic [1:0]
   {
      DTC_DIV_NONE = 2'h0,
      DTC_DIV_FROM_C0 = 2'h1,
      DTC_DIV_FROM_C1 = 2'h2
   } dtc_divsel_e;

endpackage : dtc_pkg

`default_nettype wire

// ==== verilog/dtc_timer.sv ====
/*
   dtc_timer: two 8-bit count-up timer/event counters behind an APB slave,
   with preload, event/timer/pulse-width modes, overflow flags, wake pulses
   and a frequency divider output on port A bit 3.
   Assumes external inputs and rtc/time-base ticks are synchronous to pclk;
   ticks are one-cycle enables.
*/
// Register access over APB was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - two 8-bit counters, counter 1 may count counter 0 overflows; each increments once per selected edge.
// - counter 0 select bit 5: 0 rtc tick, 1 system clock or clock/4.
// - counter 1 select bit 5: 1 clock/4, 0 build-time chosen source.
// - data write stores preload; data read returns live count.
// - mode bits 7:6: 01 event, 10 timer, 11 pulse width.
// - event mode counts edges of the external input pin.
// - event/timer count up to FFH, then reload preload and continue.
// - overflow sets flag bit 6 of irq control a, bit 4 of b.
// - edge bit 3: 0 rising, 1 falling input edge.
// - pulse mode counts clock after active edge, stops and clears run.
// - after measurement count holds until software sets run again.
// - pulse mode counts internal clock, started and stopped by edges.
// - pulse mode overflow also reloads and raises the interrupt flag.
// - run bit 4 enables counting; only software changes it outside pulse mode.
// - overflow gives wake pulse; one counter drives divider onto port a bit 3.
// - port a bit 3 cleared enables divider output, set disables.
// - cleared interrupt enable blocks the request in every mode.
// - stopped counter: data write loads preload and counter.
// - running counter: data write only loads preload.
// - count is frozen while the data register is being read.
// - control bits 2:0 read as zero.
module dtc_timer
   import dtc_pkg::*;
#(
   parameter bit C0_SYS_DIV4 = 1'b1,
   parameter dtc_c1src_e C1_SOURCE = DTC_C1_FROM_OVF0,
   parameter dtc_divsel_e DIV_SOURCE = DTC_DIV_FROM_C0
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output var logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // clock ticks and external inputs
   input wire logic rtc_tick,
   input wire logic timebase_tick,
   input wire logic counter0_input,
   input wire logic counter1_input,
   // interrupt requests and wake pulses
   output logic counter0_irq_req,
   output logic counter1_irq_req,
   output var logic counter0_overflow,
   output var logic counter1_overflow,
   // divider
   output var logic freq_divider_out,
   output logic port_a_bit3
);

   // byte address of a register index
   function automatic logic [7:0] dtc_addr(input logic [7:0] idx);
      dtc_addr = {idx[5:0], 2'b00};
   endfunction : dtc_addr

   // next count: increment or reload on overflow
   function automatic logic [7:0] dtc_next(input logic [7:0] cur,
                                           input logic [7:0] pre);
      dtc_next = (cur == DTC_CNT_MAX) ? pre : cur + DTC_CNT_ONE;
   endfunction : dtc_next

   logic [7:0] cnt [2], preload [2], ctl [2];
   logic [7:0] irq_a, irq_b, port_a, next_rdata;
   logic [1:0] div4_cnt;
   logic div4_tick, mapped, wr_en, rd_setup, sel_ia, sel_ib, sel_pa;
   logic sync1 [2], sync2 [2], prev [2];
   dtc_pw_e pw_state [2];
   logic int_clk [2], tick [2], ovf [2], pw_done [2];
   logic act_edge [2], end_edge [2], rd_block [2], sel_d [2], sel_c [2];

   // address decode
   always_comb
   begin
      {sel_d[0], sel_d[1], sel_c[0], sel_c[1], sel_ia, sel_ib, sel_pa} = 7'h00;
      if (paddr == dtc_addr(DTC_IDX_C0_DATA))
         sel_d[0] = 1'b1;
      else if (paddr == dtc_addr(DTC_IDX_C0_CTL))
         sel_c[0] = 1'b1;
      else if (paddr == dtc_addr(DTC_IDX_C1_DATA))
         sel_d[1] = 1'b1;
      else if (paddr == dtc_addr(DTC_IDX_C1_CTL))
         sel_c[1] = 1'b1;
      else if (paddr == dtc_addr(DTC_IDX_IRQ_A))
         sel_ia = 1'b1;
      else if (paddr == dtc_addr(DTC_IDX_IRQ_B))
         sel_ib = 1'b1;
      else if (paddr == dtc_addr(DTC_IDX_PORT_A))
         sel_pa = 1'b1;
   end

   assign mapped = sel_d[0] | sel_d[1] | sel_c[0] | sel_c[1] | sel_ia |
                   sel_ib | sel_pa;
   // writes take effect only at the access edge
   assign wr_en = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   // read data is captured at setup, so the slave never waits
   assign pready = psel & penable;
   assign pslverr = psel & penable & ~mapped;

   // read multiplexer; data registers return the live count
   always_comb
   begin
      next_rdata = 8'h00;
      if (sel_d[0])
         next_rdata = cnt[0];
      else if (sel_c[0])
         next_rdata = ctl[0] & DTC_CTL_MASK;
      else if (sel_d[1])
         next_rdata = cnt[1];
      else if (sel_c[1])
         next_rdata = ctl[1] & DTC_CTL_MASK;
      else if (sel_ia)
         next_rdata = irq_a;
      else if (sel_ib)
         next_rdata = irq_b;
      else if (sel_pa)
         next_rdata = port_a;
   end

   // read data register, loaded in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h0000_0000;
      else if (rd_setup)
         prdata <= {24'h00_0000, next_rdata};
   end

   // system clock / 4 enable
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         div4_cnt <= 2'h0;
      else
         div4_cnt <= div4_cnt + 2'h1;
   end
   assign div4_tick = (div4_cnt == DTC_DIV4_LAST);

   // internal clock selection per counter
   always_comb
   begin
      if (ctl[0][DTC_CTL_SRC])
         int_clk[0] = C0_SYS_DIV4 ? div4_tick : 1'b1;
      else
         int_clk[0] = rtc_tick;
      if (ctl[1][DTC_CTL_SRC])
         int_clk[1] = div4_tick;
      else if (C1_SOURCE == DTC_C1_FROM_OVF0)
         int_clk[1] = ovf[0];
      else if (C1_SOURCE == DTC_C1_FROM_SYS)
         int_clk[1] = 1'b1;
      else
         int_clk[1] = timebase_tick;
   end

   // per-counter logic; both counters share one structure
   for (genvar i = 0; i < 2; i++)
   begin : g_cnt
      logic rise;
      logic fall;
      dtc_mode_e mode;
      logic run;

      assign mode = dtc_mode_e'(ctl[i][DTC_CTL_MODE_HI:DTC_CTL_MODE_LO]);
      assign run = ctl[i][DTC_CTL_RUN];

      // two-stage synchroniser plus history; only sync2 feeds edges
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            {sync1[i], sync2[i], prev[i]} <= 3'h0;
         else
         begin
            sync1[i] <= (i == 0) ? counter0_input : counter1_input;
            sync2[i] <= sync1[i];
            prev[i] <= sync2[i];
         end
      end

      assign rise = sync2[i] & ~prev[i];
      assign fall = ~sync2[i] & prev[i];
      assign act_edge[i] = ctl[i][DTC_CTL_EDGE] ? fall : rise;
      assign end_edge[i] = ctl[i][DTC_CTL_EDGE] ? rise : fall;

      // a read of the count freezes it for the whole transfer
      assign rd_block[i] = psel & ~pwrite & sel_d[i];

      // count enable from the mode
      always_comb
      begin
         case (mode)
            DTC_MODE_EVENT: tick[i] = act_edge[i];
            DTC_MODE_TIMER: tick[i] = int_clk[i];
            DTC_MODE_PULSE:
               tick[i] = int_clk[i] & (pw_state[i] == DTC_PW_COUNT);
            default: tick[i] = 1'b0;
         endcase
         // the stop edge ends the count, so a coincident tick is dropped
         tick[i] = tick[i] & run & ~rd_block[i] & ~pw_done[i];
      end

      assign ovf[i] = tick[i] & (cnt[i] == DTC_CNT_MAX);
      assign pw_done[i] = run & (mode == DTC_MODE_PULSE) &
                          (pw_state[i] == DTC_PW_COUNT) & end_edge[i];

      // pulse-width state: armed until the active edge, then counting
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            pw_state[i] <= DTC_PW_ARMED;
         else if (!run || mode != DTC_MODE_PULSE)
            pw_state[i] <= DTC_PW_ARMED;
         else
            case (pw_state[i])
               DTC_PW_ARMED:
                  if (act_edge[i])
                     pw_state[i] <= DTC_PW_COUNT;
               DTC_PW_COUNT:
                  if (end_edge[i])
                     pw_state[i] <= DTC_PW_ARMED;
               default: pw_state[i] <= DTC_PW_ARMED;
            endcase
      end

      // control register; a software write wins over the auto clear
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            ctl[i] <= DTC_CTL_RESET;
         else if (wr_en && sel_c[i])
            ctl[i] <= pwdata[7:0] & DTC_CTL_MASK;
         else if (pw_done[i])
            ctl[i][DTC_CTL_RUN] <= 1'b0;
      end

      // preload register
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            preload[i] <= DTC_CNT_RESET;
         else if (wr_en && sel_d[i])
            preload[i] <= pwdata[7:0];
      end

      // counter: loads only when stopped, else counts and reloads
      always_ff @(posedge pclk or negedge presetn)
      begin
         if (!presetn)
            cnt[i] <= DTC_CNT_RESET;
         else if (wr_en && sel_d[i] && !run)
            cnt[i] <= pwdata[7:0];
         else if (tick[i])
            cnt[i] <= dtc_next(cnt[i], preload[i]);
      end

      chk_cnt_increment: assert property (
         @(posedge pclk) disable iff (!presetn)
         tick[i] && cnt[i] != DTC_CNT_MAX |=> cnt[i] == $past(cnt[i]) + 8'h01)
         else $error("counter did not step by one");
      chk_ovf_reload: assert property (
         @(posedge pclk) disable iff (!presetn)
         ovf[i] |=> cnt[i] == $past(preload[i]))
         else $error("overflow did not reload preload");
      chk_stopped_load: assert property (
         @(posedge pclk) disable iff (!presetn)
         wr_en && sel_d[i] && !run
         |=> cnt[i] == $past(pwdata[7:0]) && preload[i] == cnt[i])
         else $error("stopped write did not load counter");
      chk_running_write: assert property (
         @(posedge pclk) disable iff (!presetn)
         wr_en && sel_d[i] && run && !tick[i]
         |=> cnt[i] == $past(cnt[i]) && preload[i] == $past(pwdata[7:0]))
         else $error("running write disturbed counter");
      chk_read_freeze: assert property (
         @(posedge pclk) disable iff (!presetn)
         rd_setup && sel_d[i] && !wr_en
         |=> cnt[i] == $past(cnt[i]) && prdata[7:0] == cnt[i])
         else $error("count moved during read");
      chk_pw_stop: assert property (
         @(posedge pclk) disable iff (!presetn)
         pw_done[i] && !(wr_en && sel_c[i])
         |=> !ctl[i][DTC_CTL_RUN] && cnt[i] == $past(cnt[i]) ##1
             cnt[i] == $past(cnt[i]))
         else $error("pulse measurement did not stop");
      chk_pw_hold: assert property (
         @(posedge pclk) disable iff (!presetn)
         mode == DTC_MODE_PULSE && !run && !(wr_en && sel_d[i])
         |=> cnt[i] == $past(cnt[i]))
         else $error("count changed after measurement");
   end

   // interrupt control a and b; a hardware set wins over a software clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_a <= DTC_IRQ_RESET;
         irq_b <= DTC_IRQ_RESET;
      end
      else
      begin
         if (wr_en && sel_ia)
            irq_a <= pwdata[7:0] & DTC_IRQA_MASK;
         if (wr_en && sel_ib)
            irq_b <= pwdata[7:0] & DTC_IRQB_MASK;
         if (ovf[0])
            irq_a[DTC_IRQA_FLAG0] <= 1'b1;
         if (ovf[1])
            irq_b[DTC_IRQB_FLAG1] <= 1'b1;
      end
   end

   // request only where the enable is set, in every mode
   assign counter0_irq_req = irq_a[DTC_IRQA_FLAG0] & irq_a[DTC_IRQA_EN0];
   assign counter1_irq_req = irq_b[DTC_IRQB_FLAG1] & irq_b[DTC_IRQB_EN1];

   // wake pulses, one cycle after the overflow
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         {counter0_overflow, counter1_overflow} <= 2'h0;
      else
         {counter0_overflow, counter1_overflow} <= {ovf[0], ovf[1]};
   end

   // port a output latch; resets high so the divider starts disabled
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         port_a <= DTC_PORT_A_RESET;
      else if (wr_en && sel_pa)
         port_a <= pwdata[7:0];
   end

   // divider toggles on each overflow of the chosen counter
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         freq_divider_out <= 1'b0;
      else if ((DIV_SOURCE == DTC_DIV_FROM_C0 && ovf[0]) ||
               (DIV_SOURCE == DTC_DIV_FROM_C1 && ovf[1]))
         freq_divider_out <= ~freq_divider_out;
   end

   // latch bit 3 low hands the pin to the divider
   assign port_a_bit3 = (DIV_SOURCE != DTC_DIV_NONE &&
                         !port_a[DTC_PA_DIV_BIT]) ?
                        freq_divider_out : port_a[DTC_PA_DIV_BIT];

   chk_flag0_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      ovf[0] |=> irq_a[DTC_IRQA_FLAG0] ##1 ($stable(irq_a[DTC_IRQA_FLAG0])
                 || $past(wr_en && sel_ia)))
      else $error("counter 0 overflow flag not set");
   chk_flag1_set: assert property (
      @(posedge pclk) disable iff (!presetn)
      ovf[1] |=> irq_b[DTC_IRQB_FLAG1])
      else $error("counter 1 overflow flag not set");
   chk_irq_gate: assert property (
      @(posedge pclk) disable iff (!presetn)
      !irq_a[DTC_IRQA_EN0] || !irq_a[DTC_IRQA_FLAG0] |-> !counter0_irq_req)
      else $error("request without enable");
   chk_wake_pulse: assert property (
      @(posedge pclk) disable iff (!presetn)
      ovf[1] |=> counter1_overflow ##1 (!counter1_overflow || $past(ovf[1])))
      else $error("wake pulse missing");
   chk_ctl_zero: assert property (
      @(posedge pclk) disable iff (!presetn)
      rd_setup && (sel_c[0] || sel_c[1]) |=> prdata[2:0] == 3'h0)
      else $error("unused control bits read nonzero");
   chk_div_pin: assert property (
      @(posedge pclk) disable iff (!presetn)
      DIV_SOURCE != DTC_DIV_NONE && port_a[DTC_PA_DIV_BIT]
      |-> port_a_bit3)
      else $error("divider not disabled by latch");

endmodule : dtc_timer

`default_nettype wire
